// >>> verilog/esi_pkg.sv
package esi_pkg;

    // Request lines and interruption code layout.
    localparam int ESI_LINES = 8;
    localparam int ESI_USED = 6;
    localparam int ESI_FIRST_USED = 2;
    localparam int ESI_MASK_BIT = 7;
    localparam int ESI_CODE_FIRST = 16;
    localparam int ESI_CODE_LAST = 25;
    localparam int ESI_SRC_FIRST = 26;
    localparam int ESI_PSW_BITS = 64;

    // Fixed storage locations for the status word swap.
    localparam logic [23:0] ESI_OLD_PSW_ADDR = 24'h000018;
    localparam logic [23:0] ESI_NEW_PSW_ADDR = 24'h000058;

    // Request pulse timing seen on the lines, and its cycle counts at 100 MHz.
    localparam int ESI_CLK_PERIOD_NS = 10;
    localparam int ESI_PULSE_MIN_NS = 500;
    localparam int ESI_PULSE_MAX_NS = 1000;
    localparam int ESI_GAP_MIN_NS = 500;
    localparam int ESI_PULSE_MIN_CYC =
        (ESI_PULSE_MIN_NS + ESI_CLK_PERIOD_NS - 1) / ESI_CLK_PERIOD_NS;
    localparam int ESI_PULSE_MAX_CYC = ESI_PULSE_MAX_NS / ESI_CLK_PERIOD_NS;
    localparam int ESI_GAP_MIN_CYC =
        (ESI_GAP_MIN_NS + ESI_CLK_PERIOD_NS - 1) / ESI_CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [11:0] ESI_STATUS_OFS = 12'h000;
    localparam logic [11:0] ESI_CLEAR_OFS = 12'h004;
    localparam logic [11:0] ESI_ENABLE_OFS = 12'h008;
    localparam logic [11:0] ESI_PENDING_OFS = 12'h00c;
    localparam logic [11:0] ESI_CODE_OFS = 12'h010;
    localparam logic [11:0] ESI_SWREQ_OFS = 12'h014;

    // Event bits of status, clear and enable.
    localparam int ESI_EVT_BITS = 2;
    localparam int ESI_EVT_TAKEN = 0;
    localparam int ESI_EVT_MERGED = 1;

    // Reset values.
    localparam logic [1:0] ESI_ENABLE_RST = 2'h0;
    localparam logic [5:0] ESI_PENDING_RST = 6'h00;

    typedef enum logic [1:0] {
        ESI_ST_IDLE = 2'b00,
        ESI_ST_STORE = 2'b01,
        ESI_ST_FETCH = 2'b10
    } esi_state_t;

endpackage : esi_pkg

// >>> verilog/esi_capture.sv
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module esi_capture (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // External request lines.
    input wire logic [7:0] sigIn,
    // Processor side.
    input wire logic cpuBoundary,
    input wire logic [0:63] pswCur,
    output logic extHold,
    output logic pswLoad,
    output logic [0:63] pswNew,
    // Storage port.
    output logic memReq,
    output logic memWe,
    output logic [23:0] memAddr,
    output logic [0:63] memWdata,
    input wire logic memAck,
    input wire logic [0:63] memRdata,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Interrupt.
    output logic irq
);

    logic [5:0] syncA;
    logic [5:0] syncB;
    logic [5:0] syncC;
    logic [5:0] edges;

    // Two-stage synchroniser and edge detector per used line.
    genvar k;
    generate
        for (k = 0; k < esi_pkg::ESI_USED; k++) begin : gLine
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    syncA[k] <= 1'b0;
                    syncB[k] <= 1'b0;
                    syncC[k] <= 1'b0;
                end else begin
                    syncA[k] <= sigIn[k + esi_pkg::ESI_FIRST_USED];
                    syncB[k] <= syncA[k];
                    syncC[k] <= syncB[k];
                end
            end
            assign edges[k] = syncB[k] & ~syncC[k];
        end
    endgenerate

    esi_pkg::esi_state_t state;
    esi_pkg::esi_state_t next_state;
    logic [5:0] pending;
    logic [5:0] next_pending;
    logic [5:0] lastCode;
    logic [5:0] next_lastCode;
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] enable;
    logic [1:0] next_enable;
    logic next_extHold;
    logic next_pswLoad;
    logic [0:63] next_pswNew;
    logic next_memReq;
    logic next_memWe;
    logic [23:0] next_memAddr;
    logic [0:63] next_memWdata;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_irq;
    logic take;
    logic busWrite;
    logic [5:0] clearMask;
    logic [5:0] swSet;
    logic [1:0] setEvt;
    logic [1:0] clrEvt;
    logic [0:63] oldPsw;

    always_comb begin
        next_state = state;
        next_extHold = extHold;
        next_pswLoad = 1'b0;
        next_pswNew = pswNew;
        next_memReq = memReq;
        next_memWe = memWe;
        next_memAddr = memAddr;
        next_memWdata = memWdata;
        next_lastCode = lastCode;
        setEvt = 2'h0;
        clrEvt = 2'h0;
        swSet = 6'h00;
        next_enable = enable;
        busWrite = psel & penable & pready & pwrite;
        take = (state == esi_pkg::ESI_ST_IDLE) && cpuBoundary
            && pswCur[esi_pkg::ESI_MASK_BIT] && (pending != 6'h00);
        oldPsw = pswCur;
        oldPsw[esi_pkg::ESI_CODE_FIRST:esi_pkg::ESI_CODE_LAST] = 10'h000;
        for (int b = 0; b < esi_pkg::ESI_USED; b++) begin
            oldPsw[esi_pkg::ESI_SRC_FIRST + b] = pending[b];
        end
        case (state)
            esi_pkg::ESI_ST_IDLE: begin
                if (take) begin
                    next_lastCode = pending;
                    next_extHold = 1'b1;
                    next_memReq = 1'b1;
                    next_memWe = 1'b1;
                    next_memAddr = esi_pkg::ESI_OLD_PSW_ADDR;
                    next_memWdata = oldPsw;
                    next_state = esi_pkg::ESI_ST_STORE;
                end
            end
            esi_pkg::ESI_ST_STORE: begin
                if (memAck) begin
                    next_memWe = 1'b0;
                    next_memAddr = esi_pkg::ESI_NEW_PSW_ADDR;
                    next_state = esi_pkg::ESI_ST_FETCH;
                end
            end
            esi_pkg::ESI_ST_FETCH: begin
                if (memAck) begin
                    next_pswNew = memRdata;
                    next_pswLoad = 1'b1;
                    next_extHold = 1'b0;
                    next_memReq = 1'b0;
                    setEvt[esi_pkg::ESI_EVT_TAKEN] = 1'b1;
                    next_state = esi_pkg::ESI_ST_IDLE;
                end
            end
            default: begin
                next_extHold = 1'b0;
                next_memReq = 1'b0;
                next_state = esi_pkg::ESI_ST_IDLE;
            end
        endcase
        if (busWrite && paddr == esi_pkg::ESI_CLEAR_OFS) begin
            clrEvt = pwdata[esi_pkg::ESI_EVT_BITS-1:0];
        end
        if (busWrite && paddr == esi_pkg::ESI_ENABLE_OFS) begin
            next_enable = pwdata[esi_pkg::ESI_EVT_BITS-1:0];
        end
        if (busWrite && paddr == esi_pkg::ESI_SWREQ_OFS) begin
            swSet = pwdata[esi_pkg::ESI_USED-1:0];
        end
        clearMask = take ? pending : 6'h00;
        // New edges are ORed after the clear so they survive a capture.
        next_pending = (pending & ~clearMask) | edges | swSet;
        if ((edges & pending & ~clearMask) != 6'h00) begin
            setEvt[esi_pkg::ESI_EVT_MERGED] = 1'b1;
        end
        next_status = (status & ~clrEvt) | setEvt;
        next_irq = |(next_status & next_enable);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= esi_pkg::ESI_ST_IDLE;
            pending <= esi_pkg::ESI_PENDING_RST;
            lastCode <= 6'h00;
            status <= 2'h0;
            enable <= esi_pkg::ESI_ENABLE_RST;
            extHold <= 1'b0;
            pswLoad <= 1'b0;
            pswNew <= 64'h0;
            memReq <= 1'b0;
            memWe <= 1'b0;
            memAddr <= 24'h000000;
            memWdata <= 64'h0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            pending <= next_pending;
            lastCode <= next_lastCode;
            status <= next_status;
            enable <= next_enable;
            extHold <= next_extHold;
            pswLoad <= next_pswLoad;
            pswNew <= next_pswNew;
            memReq <= next_memReq;
            memWe <= next_memWe;
            memAddr <= next_memAddr;
            memWdata <= next_memWdata;
            irq <= next_irq;
        end
    end

    // APB answer: one wait cycle, then pready with data and error.
    always_comb begin
        next_pready = psel & penable & ~pready;
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            case (paddr)
                esi_pkg::ESI_STATUS_OFS: next_prdata = {30'h0, status};
                esi_pkg::ESI_CLEAR_OFS: next_prdata = 32'h00000000;
                esi_pkg::ESI_ENABLE_OFS: next_prdata = {30'h0, enable};
                esi_pkg::ESI_PENDING_OFS: next_prdata = {26'h0, pending};
                esi_pkg::ESI_CODE_OFS: next_prdata = {26'h0, lastCode};
                esi_pkg::ESI_SWREQ_OFS: next_prdata = 32'h00000000;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Source bits of the stored word, bit 0 standing for line two.
    logic [5:0] srcField;
    genvar b;
    generate
        for (b = 0; b < esi_pkg::ESI_USED; b++) begin : gSrc
            assign srcField[b] = memWdata[esi_pkg::ESI_SRC_FIRST + b];
        end
    endgenerate

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Checks on capture, on the status word swap and on the register answer.
    code_zero_a: assert property (
        memReq && memWe |-> memWdata[16:25] == 10'h000)
        else $error("code bits 16-25 not zero");
    code_map_a: assert property (
        memReq && memWe |-> srcField == lastCode)
        else $error("source bits differ from captured code");
    edge_latch_a: assert property (
        (edges != 6'h00) |=> ((pending & $past(edges)) == $past(edges)))
        else $error("request edge not pending");
    keep_pending_a: assert property (
        !take |=> ((pending & $past(pending)) == $past(pending)))
        else $error("pending request lost without an interruption");
    mask_gate_a: assert property (
        $rose(extHold) |-> $past(pswCur[7]) && $past(cpuBoundary))
        else $error("interruption taken while masked or off boundary");
    masked_wait_a: assert property (
        !pswCur[esi_pkg::ESI_MASK_BIT] |=> !$rose(extHold))
        else $error("interruption started under a zero mask bit");
    store_addr_a: assert property (
        $rose(memReq) |-> memWe && memAddr == esi_pkg::ESI_OLD_PSW_ADDR)
        else $error("old status word not stored at 24");
    fetch_addr_a: assert property (
        $fell(memWe) && memReq |-> memAddr == esi_pkg::ESI_NEW_PSW_ADDR)
        else $error("new status word not fetched from 88");
    fetch_load_a: assert property (
        state == esi_pkg::ESI_ST_FETCH && memAck |=> pswLoad && !memReq)
        else $error("fetched word not loaded after acknowledge");
    req_stable_a: assert property (
        memReq && !memAck |=> $stable(memAddr) && $stable(memWe) && $stable(memWdata))
        else $error("storage request changed before acknowledge");
    load_pulse_a: assert property (
        pswLoad |=> !pswLoad)
        else $error("load strobe longer than one cycle");
    load_word_a: assert property (
        pswLoad |-> pswNew == $past(memRdata) && !extHold && status[0])
        else $error("loaded word or taken flag wrong");
    boundary_hold_a: assert property (
        $rose(extHold) |-> $past(state) == esi_pkg::ESI_ST_IDLE)
        else $error("interruption started mid sequence");
    hold_swap_a: assert property (
        extHold |-> memReq)
        else $error("processor held with no swap in progress");
    idle_quiet_a: assert property (
        state == esi_pkg::ESI_ST_IDLE |-> !memReq)
        else $error("storage request while idle");
    report_clear_a: assert property (
        $rose(extHold) |-> (pending & lastCode & ~$past(edges | swSet)) == 6'h00)
        else $error("reported request still pending");
    report_code_a: assert property (
        $rose(extHold) |-> lastCode == $past(pending) && lastCode != 6'h00)
        else $error("reported code differs from pending requests");
    merge_flag_a: assert property (
        (edges & pending) != 6'h00 && !take |=> status[1])
        else $error("merged request not flagged");
    single_edge_a: assert property (
        (edges != 6'h00) |=> (edges & $past(edges)) == 6'h00)
        else $error("edge seen twice in a row");
    no_stall_a: assert property (
        !(extHold && state == esi_pkg::ESI_ST_IDLE))
        else $error("hold left high while idle");
    capture_keep_a: assert property (
        take |=> pending == ($past(edges) | $past(swSet)))
        else $error("request arriving at capture was lost");
    set_wins_a: assert property (
        (setEvt & clrEvt) != 2'h0 |=> (status & $past(setEvt & clrEvt)) == $past(setEvt & clrEvt))
        else $error("status clear beat a new event");
    irq_level_a: assert property (
        irq == |(status & enable))
        else $error("interrupt level differs from enabled status");
    enable_write_a: assert property (
        busWrite && paddr == esi_pkg::ESI_ENABLE_OFS |=> enable == $past(pwdata[1:0]))
        else $error("enable write did not land");
    apb_wait_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("apb answer longer than one cycle");
    apb_error_a: assert property (
        pready && pslverr |-> prdata == 32'h00000000)
        else $error("error answer carries data");

    // Main scenarios that the tests are expected to reach.
    take_c: cover property ($rose(extHold) ##[1:20] pswLoad);
    merge_c: cover property ((edges & pending) != 6'h00);
    keep_c: cover property (take && (edges & pending) != 6'h00);
    irq_c: cover property ($rose(irq));
    error_c: cover property (pready && pslverr);

endmodule : esi_capture

// >>> testbench/esi_requester.sv
`timescale 1ns/1ps
module esi_requester (
    // Request lines towards the capture block.
    output logic [7:0] sigOut
);
    initial sigOut = 8'h00;

    // Each pulse is high 600 ns, then low 500 ns, and is placed off the clock edge.
    task automatic pulse(input logic [7:0] m);
        #3;
        sigOut = sigOut | m;
        #600;
        sigOut = sigOut & ~m;
        #500;
    endtask : pulse

    // Holds lines high for good, as a faulty requester would.
    task automatic stick(input logic [7:0] m);
        #3;
        sigOut = sigOut | m;
    endtask : stick
endmodule : esi_requester

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sigIn;
    logic cpuBoundary = 1'b0;
    logic [0:63] pswCur = 64'h0023_4567_89ab_cdef;
    logic [0:63] memRdata = 64'hfedc_ba98_7654_3210;
    logic [0:63] pswNew, memWdata, storeWord;
    logic extHold, pswLoad, memReq, memWe, pready, pslverr, irq, err;
    logic memAck = 1'b0;
    logic [23:0] memAddr, storeAddr, fetchAddr;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int bad_count = 0, checks_done = 0, takes = 0, loads = 0;

    always #5 core_clk = ~core_clk;

    esi_requester u_esi_requester (.sigOut(sigIn));

    esi_capture u_esi_capture (.core_clk(core_clk), .rstn(rstn), .sigIn(sigIn),
        .cpuBoundary(cpuBoundary), .pswCur(pswCur), .extHold(extHold), .pswLoad(pswLoad),
        .pswNew(pswNew), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));

    // Storage answers each transfer one cycle after it is requested and logs it.
    always @(posedge core_clk) begin
        memAck <= memReq && !memAck;
        if (pswLoad === 1'b1) loads++;
        if (memReq === 1'b1 && memAck === 1'b1) begin
            if (memWe === 1'b1) begin
                storeWord = memWdata;
                storeAddr = memAddr;
            end else begin
                fetchAddr = memAddr;
                takes++;
            end
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("bus answer", 1, pready);
    endtask : apb

    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("bus error", 0, err);
        chk(n, e, rd);
    endtask : rdchk

    // Waits a bounded time for the interruption count, then compares it.
    task automatic waitTake(input int n);
        for (int i = 0; i < 200 && takes < n; i++) @(posedge core_clk);
        repeat (20) @(posedge core_clk);
        chk("interruptions", n, takes);
        chk("status loads", n, loads);
    endtask : waitTake

    function automatic logic [0:63] expWord(input logic [5:0] p);
        logic [0:63] e;
        e = pswCur;
        e[16:25] = 10'h000;
        for (int k = 0; k < 6; k++) e[26 + k] = p[k];
        return e;
    endfunction : expWord

    initial begin
        #200us;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        rdchk("enable reset", esi_pkg::ESI_ENABLE_OFS, 32'h0);
        rdchk("pending reset", esi_pkg::ESI_PENDING_OFS, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 1, err);
        apb(1'b1, esi_pkg::ESI_ENABLE_OFS, 32'h3);
        rdchk("enable", esi_pkg::ESI_ENABLE_OFS, 32'h3);
        u_esi_requester.pulse(8'h07);
        rdchk("pending", esi_pkg::ESI_PENDING_OFS, 32'h1);
        pswCur[7] <= 1'b1;
        waitTake(0);
        pswCur[7] <= 1'b0;
        cpuBoundary <= 1'b1;
        waitTake(0);
        u_esi_requester.pulse(8'h04);
        rdchk("merged status", esi_pkg::ESI_STATUS_OFS, 32'h2);
        chk("irq set", 1, irq);
        apb(1'b1, esi_pkg::ESI_CLEAR_OFS, 32'h3);
        rdchk("cleared status", esi_pkg::ESI_STATUS_OFS, 32'h0);
        chk("irq clear", 0, irq);
        pswCur[7] <= 1'b1;
        waitTake(1);
        chk("store addr", 24, storeAddr);
        chk("fetch addr", 88, fetchAddr);
        chk("new word", memRdata, pswNew);
        chk("code", expWord(6'h01), storeWord);
        chk("extHold", 0, extHold);
        rdchk("pending after", esi_pkg::ESI_PENDING_OFS, 32'h0);
        chk("irq taken", 1, irq);
        for (int i = 1; i < 6; i++) begin
            u_esi_requester.pulse(8'h04 << i);
            waitTake(1 + i);
            chk("line code", expWord(6'h01 << i), storeWord);
        end
        pswCur[7] <= 1'b0;
        apb(1'b1, esi_pkg::ESI_SWREQ_OFS, 32'h3);
        rdchk("swreq pending", esi_pkg::ESI_PENDING_OFS, 32'h3);
        pswCur[7] <= 1'b1;
        waitTake(7);
        chk("joint code", expWord(6'h03), storeWord);
        rdchk("code reg", esi_pkg::ESI_CODE_OFS, 32'h3);
        u_esi_requester.stick(8'h80);
        repeat (60) @(posedge core_clk);
        waitTake(8);
        chk("stuck hold", 0, extHold);
        rdchk("stuck pending", esi_pkg::ESI_PENDING_OFS, 32'h0);
        conclude();
    end
endmodule : tb_top
